/* File: rtl/can_pkg.sv */
// constants, types and register map of the can bit timing and flag block
// assumes a 250 MHz sys_clk and a 32-bit axi4-lite register bus
package can_pkg;

	// register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] OFS_CONTROL_ZERO = 8'h00;
	localparam logic [7:0] OFS_RECEIVER_FLAGS = 8'h04;
	localparam logic [7:0] OFS_RX_IRQ_EN = 8'h08;
	localparam logic [7:0] OFS_TX_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_TX_IRQ_EN = 8'h10;
	localparam logic [7:0] OFS_CONTROL_ONE = 8'h14;
	localparam logic [7:0] OFS_BIT_TIMING = 8'h18;
	localparam logic [7:0] OFS_TIMING_STATUS = 8'h1C;

	// control_zero fields
	localparam int CZ_SLEEP_REQ = 1;
	localparam int CZ_WAKEUP_EN = 2;
	// control_one fields
	localparam int C1_FILTER_SEL = 2;
	localparam int C1_MODULE_EN = 7;

	// receiver_flags fields, receiver_irq_enables uses the same layout
	localparam int RF_RX_FULL = 0;
	localparam int RF_OVERRUN = 1;
	localparam int RF_TX_ERR_LO = 2;
	localparam int RF_RX_ERR_LO = 4;
	localparam int RF_STATUS_CHANGE = 6;
	localparam int RF_WAKEUP = 7;
	localparam logic [7:0] RX_IE_MASK = 8'hC3;

	// bit_timing fields
	localparam int BT_PRESC_LO = 0;
	localparam int BT_SEG1_LO = 8;
	localparam int BT_SEG2_LO = 12;
	// timing_status fields
	localparam int TS_MODE_LO = 0;
	localparam int TS_QUANTA_LO = 8;

	// reset values
	localparam logic [7:0] RST_CONTROL_ZERO = 8'h00;
	localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
	localparam logic [7:0] RST_RECEIVER_FLAGS = 8'h00;
	localparam logic [7:0] RST_RX_IRQ_EN = 8'h00;
	localparam logic [2:0] RST_TX_IRQ_EN = 3'h0;
	localparam logic [2:0] RST_TX_SCHEDULED = 3'h0;
	localparam logic [12:0] RST_BIT_TIMING = 13'h0000;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// segment decode: code n means n plus one quanta
	localparam logic [5:0] SEG_QUANTA_OFFSET = 6'h01;
	// the sync segment is always one quantum
	localparam logic [5:0] SYNC_QUANTA = 6'h01;

	// timing of the wake-up glitch filter
	localparam int CLK_MHZ = 250;
	localparam int WAKE_FILTER_NS = 1000;
	localparam int WAKE_FILTER_CYCLES = (WAKE_FILTER_NS * CLK_MHZ + 999) / 1000;

	// controller events coming from the protocol engine
	typedef struct packed {
		logic status_change;
		logic overrun;
		logic rx_full;
		logic [1:0] rx_err_state;
		logic [1:0] tx_err_state;
	} rx_events_type;

	// bit timing configuration
	typedef struct packed {
		logic [2:0] seg2_code;
		logic [3:0] seg1_code;
		logic [5:0] presc_code;
	} timing_cfg_type;

	// power modes, one-hot
	typedef enum logic [2:0] {
		MODE_DISABLED = 3'h1,
		MODE_RUN = 3'h2,
		MODE_SLEEP = 3'h4
	} mode_type;

endpackage

/* File: rtl/can_wake_filter.sv */
// wake-up detector on the bus receive pin with optional glitch filter
// assumes the pin is asynchronous to sys_clk; low level is bus activity
`timescale 1ns/1ps
module can_wake_filter #(
	parameter int unsigned FILTER_CYCLES = can_pkg::WAKE_FILTER_CYCLES
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// pin and control
	input wire logic rx_pin,
	input wire logic filter_en,
	input wire logic armed,
	// result
	output logic wake_pulse
);
	import can_pkg::*;

	localparam int CNT_W = $clog2(FILTER_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILTER_CYCLES - 1);

	logic rx_meta_q; // first synchroniser stage
	logic rx_sync_q; // second synchroniser stage
	logic [CNT_W-1:0] dom_cnt_q; // consecutive dominant cycles
	logic dominant; // bus shows activity

	// two-flop synchroniser for the pin
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			rx_meta_q <= 1'h1;
			rx_sync_q <= 1'h1;
		end
		else if (ce)
		begin
			rx_meta_q <= rx_pin;
			rx_sync_q <= rx_meta_q;
		end
	end

	assign dominant = !rx_sync_q;

	// length of the current dominant stretch
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			dom_cnt_q <= '0;
		else if (ce)
		begin
			if (!dominant || !armed)
				dom_cnt_q <= '0;
			else if (dom_cnt_q != CNT_LAST)
				dom_cnt_q <= dom_cnt_q + 1'h1;
		end
	end

	// raw or filtered activity raises the wake pulse
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			wake_pulse <= 1'h0;
		else if (ce)
		begin
			if (!armed)
				wake_pulse <= 1'h0;
			else if (filter_en)
				wake_pulse <= dominant && (dom_cnt_q == CNT_LAST);
			else
				wake_pulse <= dominant;
		end
	end

endmodule // can_wake_filter

/* File: rtl/can_bit_timing_flags.sv */
// bit timing, receiver flags, wake-up and interrupts of a can controller
// assumes an axi4-lite master on sys_clk and event inputs on sys_clk;
// the bus receive pin is asynchronous and is synchronised here
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps

// Function
// - seg2 code n gives n+1 quanta
// - seg1 code n gives n+1 quanta
// - bit is prescaler times one plus segments
// - flag clears by written one after condition
// - flag and own enable raise request
// - disabled after reset, registers still accessible
// - wake from sleep on bus activity
// - optional low-pass filter before wake detection
// - four requests, local enable and cpu mask
// - three buffers, empty flag when unscheduled
module can_bit_timing_flags #(
	parameter int unsigned FILTER_CYCLES = can_pkg::WAKE_FILTER_CYCLES
)
(
	// clock, reset, clock enable
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// axi4-lite write address and data
	input wire logic [can_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [can_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [can_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [can_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// can side
	input wire logic bus_receive_input,
	input can_pkg::rx_events_type rx_events,
	input wire logic [2:0] tx_done,
	input wire logic cpu_irq_mask,
	// timing and mode
	output logic bit_tick,
	output logic sample_tick,
	output logic module_active,
	output logic sleep_ack,
	output logic [2:0] tx_request,
	// interrupts
	output logic wakeup_irq,
	output logic error_irq,
	output logic receive_irq,
	output logic transmit_irq,
	output logic irq
);
	import can_pkg::*;

	// write channel holding state
	logic aw_full_q; // address captured
	logic w_full_q; // data captured
	logic [ADDR_W-1:0] wr_addr_q;
	logic [DATA_W-1:0] wr_data_q;
	logic [3:0] wr_strb_q;
	logic wr_en; // write takes effect this cycle
	logic wr_hit; // write address is mapped
	logic [7:0] wr_word; // write address, word aligned
	logic [7:0] rd_word; // read address, word aligned
	logic [DATA_W-1:0] rd_mux; // read data before the register
	logic rd_hit; // read address is mapped

	// software registers
	logic [7:0] control_zero_q;
	logic [7:0] control_one_q;
	logic [7:0] rx_irq_en_q;
	logic [2:0] tx_irq_en_q;
	timing_cfg_type timing_q;

	// flags
	logic [3:0] flag_q; // wake, status change, overrun, rx full
	logic [3:0] flag_set; // hardware set this cycle
	logic [3:0] flag_clr; // software one written this cycle
	logic [7:0] receiver_flags; // register view
	logic [2:0] tx_sched_q; // buffers waiting to be sent
	logic [2:0] tx_empty; // empty flags
	logic [2:0] sched_wr; // software schedules buffers

	// mode and timing
	mode_type mode_q;
	logic wake_pulse; // activity seen while armed
	logic wake_evt; // wake that leaves sleep
	logic [5:0] tq_cnt_q; // clocks inside one quantum
	logic [4:0] q_cnt_q; // quantum index in the bit
	logic [4:0] bit_quanta; // quanta in one bit
	logic [4:0] sample_q_idx; // last quantum of seg1
	logic tq_tick; // end of a quantum

	// word aligned addresses
	assign wr_word = {wr_addr_q[7:2], 2'h0};
	assign rd_word = {s_axi_araddr[7:2], 2'h0};

	// a write completes once address and data are both in
	assign wr_en = aw_full_q && w_full_q && !s_axi_bvalid;

	// mapped offsets
	always_comb
	begin
		case (wr_word)
			OFS_CONTROL_ZERO, OFS_RECEIVER_FLAGS, OFS_RX_IRQ_EN,
			OFS_TX_FLAGS, OFS_TX_IRQ_EN, OFS_CONTROL_ONE,
			OFS_BIT_TIMING, OFS_TIMING_STATUS: wr_hit = 1'h1;
			default: wr_hit = 1'h0;
		endcase
	end

	// address and data channels taken in either order
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'h1;
			s_axi_wready <= 1'h1;
			aw_full_q <= 1'h0;
			w_full_q <= 1'h0;
			wr_addr_q <= '0;
			wr_data_q <= '0;
			wr_strb_q <= 4'h0;
		end
		else if (ce)
		begin
			// capture address
			if (s_axi_awvalid && s_axi_awready)
			begin
				wr_addr_q <= s_axi_awaddr;
				aw_full_q <= 1'h1;
				s_axi_awready <= 1'h0;
			end
			// capture data
			if (s_axi_wvalid && s_axi_wready)
			begin
				wr_data_q <= s_axi_wdata;
				wr_strb_q <= s_axi_wstrb;
				w_full_q <= 1'h1;
				s_axi_wready <= 1'h0;
			end
			// write performed, free the holders
			if (wr_en)
			begin
				aw_full_q <= 1'h0;
				w_full_q <= 1'h0;
			end
			// response taken, accept the next write
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_awready <= 1'h1;
				s_axi_wready <= 1'h1;
			end
		end
	end

	// write response
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'h0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (wr_en)
			begin
				s_axi_bvalid <= 1'h1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'h0;
		end
	end

	// control and enable registers, low byte lane
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			control_zero_q <= RST_CONTROL_ZERO;
			control_one_q <= RST_CONTROL_ONE;
			rx_irq_en_q <= RST_RX_IRQ_EN;
			tx_irq_en_q <= RST_TX_IRQ_EN;
		end
		else if (ce)
		begin
			if (wr_en && wr_strb_q[0])
			begin
				if (wr_word == OFS_CONTROL_ZERO)
					control_zero_q <= wr_data_q[7:0];
				if (wr_word == OFS_CONTROL_ONE)
					control_one_q <= wr_data_q[7:0];
				if (wr_word == OFS_RX_IRQ_EN)
					rx_irq_en_q <= wr_data_q[7:0] & RX_IE_MASK;
				if (wr_word == OFS_TX_IRQ_EN)
					tx_irq_en_q <= wr_data_q[2:0];
			end
			// a wake from sleep drops the request
			if (wake_evt)
				control_zero_q[CZ_SLEEP_REQ] <= 1'h0;
		end
	end

	// bit timing register, two byte lanes
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			timing_q <= RST_BIT_TIMING;
		else if (ce && wr_en && wr_word == OFS_BIT_TIMING)
		begin
			if (wr_strb_q[0])
				timing_q.presc_code <= wr_data_q[BT_PRESC_LO +: 6];
			if (wr_strb_q[1])
			begin
				timing_q.seg1_code <= wr_data_q[BT_SEG1_LO +: 4];
				timing_q.seg2_code <= wr_data_q[BT_SEG2_LO +: 3];
			end
		end
	end

	// sticky receiver flags; one written clears, a set in the same cycle wins
	assign flag_set = {wake_evt, rx_events.status_change,
		rx_events.overrun, rx_events.rx_full};
	assign flag_clr = (wr_en && wr_strb_q[0] && wr_word == OFS_RECEIVER_FLAGS)
		? {wr_data_q[RF_WAKEUP], wr_data_q[RF_STATUS_CHANGE],
		wr_data_q[RF_OVERRUN], wr_data_q[RF_RX_FULL]} : 4'h0;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			flag_q <= 4'h0;
		else if (ce)
			// clear ignored while the setting condition holds
			flag_q <= flag_set | (flag_q & ~flag_clr);
	end

	// register view of the receiver flags
	assign receiver_flags = {flag_q[3], flag_q[2], rx_events.rx_err_state,
		rx_events.tx_err_state, flag_q[1], flag_q[0]};

	// writing one to an empty flag schedules that buffer
	assign sched_wr = (wr_en && wr_strb_q[0] && wr_word == OFS_TX_FLAGS)
		? wr_data_q[2:0] : 3'h0;

	// transmit buffers; a finished send empties, and wins over a schedule
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			tx_sched_q <= RST_TX_SCHEDULED;
		else if (ce)
			tx_sched_q <= (tx_sched_q | sched_wr) & ~tx_done;
	end

	assign tx_empty = ~tx_sched_q;

	// power mode sequencer
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			mode_q <= MODE_DISABLED;
		else if (ce)
		begin
			case (mode_q)
				MODE_DISABLED:
					if (control_one_q[C1_MODULE_EN])
						mode_q <= MODE_RUN;
				MODE_RUN:
					if (!control_one_q[C1_MODULE_EN])
						mode_q <= MODE_DISABLED;
					else if (control_zero_q[CZ_SLEEP_REQ])
						mode_q <= MODE_SLEEP;
				MODE_SLEEP:
					if (!control_one_q[C1_MODULE_EN])
						mode_q <= MODE_DISABLED;
					else if (wake_evt || !control_zero_q[CZ_SLEEP_REQ])
						mode_q <= MODE_RUN;
				default:
					mode_q <= MODE_DISABLED;
			endcase
		end
	end

	// wake-up detection on the receive pin
	can_wake_filter #(
		.FILTER_CYCLES(FILTER_CYCLES)
	) u_wake (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.rx_pin(bus_receive_input),
		.filter_en(control_one_q[C1_FILTER_SEL]),
		.armed(mode_q == MODE_SLEEP && control_zero_q[CZ_WAKEUP_EN]),
		.wake_pulse(wake_pulse)
	);

	// wake counts only while still asleep
	assign wake_evt = wake_pulse && mode_q == MODE_SLEEP;

	// quanta per bit: sync plus both decoded segments
	assign bit_quanta = 5'(SYNC_QUANTA
		+ ({2'h0, timing_q.seg1_code} + SEG_QUANTA_OFFSET)
		+ ({3'h0, timing_q.seg2_code} + SEG_QUANTA_OFFSET));
	// index of the last seg1 quantum
	assign sample_q_idx = 5'({2'h0, timing_q.seg1_code} + SEG_QUANTA_OFFSET);
	assign tq_tick = tq_cnt_q == timing_q.presc_code;

	// prescaler: one quantum is presc_code+1 clocks, held at zero unless running
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			tq_cnt_q <= 6'h00;
		else if (ce)
		begin
			if (mode_q != MODE_RUN || tq_tick)
				tq_cnt_q <= 6'h00;
			else
				tq_cnt_q <= tq_cnt_q + 6'h01;
		end
	end

	// quantum counter and bit strobes
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			q_cnt_q <= 5'h00;
			bit_tick <= 1'h0;
			sample_tick <= 1'h0;
		end
		else if (ce)
		begin
			bit_tick <= 1'h0;
			sample_tick <= 1'h0;
			if (mode_q != MODE_RUN)
				q_cnt_q <= 5'h00;
			else if (tq_tick)
			begin
				// sample point after sync and seg1
				if (q_cnt_q == sample_q_idx)
					sample_tick <= 1'h1;
				if (q_cnt_q >= bit_quanta - 5'h01)
				begin
					q_cnt_q <= 5'h00;
					bit_tick <= 1'h1;
				end
				else
					q_cnt_q <= q_cnt_q + 5'h01;
			end
		end
	end

	// mode, buffer and interrupt outputs
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			module_active <= 1'h0;
			sleep_ack <= 1'h0;
			tx_request <= 3'h0;
			wakeup_irq <= 1'h0;
			error_irq <= 1'h0;
			receive_irq <= 1'h0;
			transmit_irq <= 1'h0;
			irq <= 1'h0;
		end
		else if (ce)
		begin
			module_active <= mode_q == MODE_RUN;
			sleep_ack <= mode_q == MODE_SLEEP;
			tx_request <= tx_sched_q;
			// each request needs flag, own enable and an open cpu mask
			wakeup_irq <= !cpu_irq_mask
				&& flag_q[3] && rx_irq_en_q[RF_WAKEUP];
			error_irq <= !cpu_irq_mask
				&& ((flag_q[2] && rx_irq_en_q[RF_STATUS_CHANGE])
				|| (flag_q[1] && rx_irq_en_q[RF_OVERRUN]));
			receive_irq <= !cpu_irq_mask
				&& flag_q[0] && rx_irq_en_q[RF_RX_FULL];
			transmit_irq <= !cpu_irq_mask
				&& |(tx_empty & tx_irq_en_q);
			irq <= !cpu_irq_mask
				&& (|(flag_q & {rx_irq_en_q[RF_WAKEUP],
				rx_irq_en_q[RF_STATUS_CHANGE], rx_irq_en_q[RF_OVERRUN],
				rx_irq_en_q[RF_RX_FULL]}) || |(tx_empty & tx_irq_en_q));
		end
	end

	// read data selection, reachable in every mode
	always_comb
	begin
		rd_mux = '0;
		rd_hit = 1'h1;
		case (rd_word)
			OFS_CONTROL_ZERO: rd_mux[7:0] = control_zero_q;
			OFS_RECEIVER_FLAGS: rd_mux[7:0] = receiver_flags;
			OFS_RX_IRQ_EN: rd_mux[7:0] = rx_irq_en_q;
			OFS_TX_FLAGS: rd_mux[2:0] = tx_empty;
			OFS_TX_IRQ_EN: rd_mux[2:0] = tx_irq_en_q;
			OFS_CONTROL_ONE: rd_mux[7:0] = control_one_q;
			OFS_BIT_TIMING:
			begin
				rd_mux[BT_PRESC_LO +: 6] = timing_q.presc_code;
				rd_mux[BT_SEG1_LO +: 4] = timing_q.seg1_code;
				rd_mux[BT_SEG2_LO +: 3] = timing_q.seg2_code;
			end
			OFS_TIMING_STATUS:
			begin
				rd_mux[TS_MODE_LO +: 3] = mode_q;
				rd_mux[TS_QUANTA_LO +: 5] = bit_quanta;
			end
			default: rd_hit = 1'h0;
		endcase
	end

	// read channel, one read at a time
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'h1;
			s_axi_rvalid <= 1'h0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'h0;
				s_axi_rvalid <= 1'h1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'h0;
				s_axi_arready <= 1'h1;
			end
		end
	end

endmodule // can_bit_timing_flags

/* File: tb/can_bit_timing_flags_props.sv */
// checker for the can bit timing and flag block, bound to its top module
// assumes sys_clk with a synchronous active-low reset and ce held high
`timescale 1ns/1ps
module can_bit_timing_flags_props #(
	parameter int unsigned FILTER_CYCLES = 4
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// register bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// can side
	input wire logic [2:0] tx_done,
	input wire logic cpu_irq_mask,
	input wire logic bit_tick,
	input wire logic sample_tick,
	input wire logic module_active,
	input wire logic sleep_ack,
	input wire logic [2:0] tx_request,
	input wire logic wakeup_irq,
	input wire logic error_irq,
	input wire logic receive_irq,
	input wire logic transmit_irq,
	input wire logic irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// reset leaves the bus idle and the controller disabled
	a_reset_idle: assert property (disable iff (1'h0)
		!rst_n && ce |=> s_axi_awready && s_axi_arready && !s_axi_bvalid
		&& !module_active && !irq) else $error("reset state wrong");
	a_irq_is_or: assert property (
		irq == (wakeup_irq || error_irq || receive_irq || transmit_irq))
		else $error("irq not the or of the four");
	a_mask_kills: assert property (
		cpu_irq_mask && ce |=> !irq) else $error("irq through mask");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready && ce |-> ##2 s_axi_bvalid)
		else $error("no write response");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce
		|=> s_axi_rvalid && !s_axi_arready) else $error("no read data");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
	a_sent_empty: assert property (
		tx_done[0] && ce |-> ##[1:2] !tx_request[0])
		else $error("sent buffer still scheduled");
	a_tick_in_run: assert property (
		bit_tick |-> module_active || $past(module_active))
		else $error("bit tick outside run");
	a_ticks_apart: assert property (!(bit_tick && sample_tick))
		else $error("sample and bit end together");
	// main scenarios
	c_wake: cover property (wakeup_irq);
	c_tick: cover property (bit_tick);
	c_tx: cover property (transmit_irq && !cpu_irq_mask);
endmodule // can_bit_timing_flags_props

bind can_bit_timing_flags can_bit_timing_flags_props #(
	.FILTER_CYCLES(FILTER_CYCLES)) u_props (.sys_clk, .rst_n, .ce,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tx_done,
	.cpu_irq_mask, .bit_tick, .sample_tick, .module_active, .sleep_ack,
	.tx_request, .wakeup_irq, .error_irq, .receive_irq, .transmit_irq, .irq);

/* File: tb/can_bus_node.sv */
// model of the far bus: recessive with pull-up, dominant bursts on request
// assumes requests come from the bench right after a sys_clk edge
`timescale 1ns/1ps
module can_bus_node (
	// request
	input wire logic sys_clk,
	input wire logic go,
	input wire logic [7:0] len,
	// line
	output logic bus_line
);
	logic [7:0] left_q = 8'h00; // cycles of dominant level still owed
	// load a burst, then count it down
	always @(posedge sys_clk)
		if (go)
			left_q <= len;
		else if (left_q != 8'h00)
			left_q <= left_q - 8'h01;
	// low is bus activity, high is the idle level
	assign bus_line = (left_q == 8'h00);
endmodule // can_bus_node

/* File: tb/can_bit_timing_flags_test.sv */
// self-checking bench of the can bit timing and flag block
// assumes the package, the design and the bus node model compiled first
`timescale 1ns/1ps
module can_bit_timing_flags_test;
	import can_pkg::*;
	logic sys_clk = 1'h0, rst_n = 1'h0;
	// register bus
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	// can side
	rx_events_type rx_events = '0;
	logic [2:0] tx_done = 3'h0, tx_request;
	logic cpu_irq_mask = 1'h0, go = 1'h0, bus_receive_input;
	logic [7:0] glen = 8'h00;
	logic bit_tick, sample_tick, module_active, sleep_ack;
	logic wakeup_irq, error_irq, receive_irq, transmit_irq, irq;
	logic [31:0] d;
	int num_errors = 0, n_checks = 0, p, q, want;
	// register rows: address, written, read back, response
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] w, e;
		logic [1:0] rsp;
	} row_type;
	row_type rows [6] = '{'{8'h08, 32'hFF, 32'hC3, RESP_OKAY},
		'{8'h10, 32'hFF, 32'h07, RESP_OKAY},
		'{8'h18, 32'h7F05, 32'h7F05, RESP_OKAY},
		'{8'h1C, 32'hFFFF, 32'h1901, RESP_OKAY},
		'{8'h04, 32'hFF, 32'h00, RESP_OKAY},
		'{8'h20, 32'h5A, 32'h00, RESP_SLVERR}};
	logic [31:0] cfg [3] = '{32'h1301, 32'h7F00, 32'h003F};

	always #2 sys_clk = ~sys_clk;

	can_bit_timing_flags #(.FILTER_CYCLES(4)) u_dut (.sys_clk, .rst_n,
		.ce(1'h1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .bus_receive_input, .rx_events,
		.tx_done, .cpu_irq_mask, .bit_tick, .sample_tick, .module_active,
		.sleep_ack, .tx_request, .wakeup_irq, .error_irq, .receive_irq,
		.transmit_irq, .irq);
	can_bus_node u_node (.sys_clk, .go, .len(glen), .bus_line(bus_receive_input));

	// verdict and end of run
	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check_word(input logic [31:0] a, e);
		n_checks++;
		if (a !== e)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got %h want %h", $time, a, e);
		end
	endtask
	task automatic check_bit(input logic a, e);
		check_word({31'h0, a}, {31'h0, e});
	endtask
	// a wait that ran out ends the run
	task automatic timed_out(input logic ok);
		if (!ok)
		begin
			check_word(32'h0, 32'h1);
			finish_test;
		end
	endtask
	// one bus write, response code left in r
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
		int n;
		logic got;
		n = 0;
		got = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge sys_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid)
			begin
				r = s_axi_bresp;
				s_axi_bready <= 1'h0;
				got = 1'h1;
			end
		end
		while (!got && n < 200);
		timed_out(got);
		// one idle edge so the next call never re-raises bready at once
		@(posedge sys_clk);
	endtask
	// one bus read, data in d and response in r
	task automatic axi_read(input logic [7:0] a);
		int n;
		logic got;
		n = 0;
		got = 1'h0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge sys_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid)
			begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'h0;
				got = 1'h1;
			end
		end
		while (!got && n < 200);
		timed_out(got);
		// one idle edge so the next call never re-raises rready at once
		@(posedge sys_clk);
	endtask
	task automatic rd_check(input logic [7:0] a, input logic [31:0] e);
		axi_read(a);
		check_word(d, e);
	endtask
	task automatic wait_high(ref logic s);
		int n;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (s !== 1'h1 && n < 400);
		timed_out(s === 1'h1);
	endtask
	// dominant burst of n cycles from the bus node
	task automatic glitch(input logic [7:0] n);
		glen <= n;
		go <= 1'h1;
		@(posedge sys_clk);
		go <= 1'h0;
	endtask

	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'h1;
		@(posedge sys_clk);
		foreach (rows[i])
		begin
			axi_write(rows[i].a, rows[i].w);
			check_word({30'h0, r}, {30'h0, rows[i].rsp});
			axi_read(rows[i].a);
			check_word({30'h0, r}, {30'h0, rows[i].rsp});
			check_word(d, rows[i].e);
		end
		// reset in mid-run
		rst_n <= 1'h0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'h1;
		@(posedge sys_clk);
		check_bit(module_active, 1'h0);
		rd_check(OFS_TIMING_STATUS, 32'h0301);
		rd_check(OFS_TX_FLAGS, 32'h7);
		rd_check(OFS_RX_IRQ_EN, 32'h0);
		axi_write(OFS_CONTROL_ONE, 32'h80);
		wait_high(module_active);
		// bit length at both ends of each field
		foreach (cfg[i])
		begin
			axi_write(OFS_BIT_TIMING, cfg[i]);
			want = (cfg[i][5:0] + 1) * (cfg[i][11:8] + cfg[i][14:12] + 3);
			wait_high(bit_tick);
			p = 0;
			q = 0;
			do
			begin
				@(posedge sys_clk);
				p++;
				if (sample_tick === 1'h1)
					q = p;
			end
			while (bit_tick !== 1'h1 && p < 300);
			check_word(p, want);
			check_word(q, (cfg[i][5:0] + 1) * (cfg[i][11:8] + 2));
		end
		// receiver flags and their requests
		axi_write(OFS_RX_IRQ_EN, 32'hC3);
		rx_events.rx_full <= 1'h1;
		wait_high(receive_irq);
		axi_write(OFS_RECEIVER_FLAGS, 32'h01);
		rd_check(OFS_RECEIVER_FLAGS, 32'h01);
		rx_events.rx_full <= 1'h0;
		@(posedge sys_clk);
		axi_write(OFS_RECEIVER_FLAGS, 32'h01);
		rd_check(OFS_RECEIVER_FLAGS, 32'h00);
		check_bit(receive_irq, 1'h0);
		rx_events.overrun <= 1'h1;
		@(posedge sys_clk);
		rx_events.overrun <= 1'h0;
		wait_high(error_irq);
		cpu_irq_mask <= 1'h1;
		repeat (2) @(posedge sys_clk);
		check_bit(irq, 1'h0);
		cpu_irq_mask <= 1'h0;
		wait_high(error_irq);
		// event lands on the same edge as the clearing write
		fork
			axi_write(OFS_RECEIVER_FLAGS, 32'h42);
			begin
				// the clear lands one edge after address and data are taken
				@(posedge sys_clk);
				rx_events.status_change <= 1'h1;
				@(posedge sys_clk);
				rx_events.status_change <= 1'h0;
			end
		join
		rd_check(OFS_RECEIVER_FLAGS, 32'h40);
		axi_write(OFS_RECEIVER_FLAGS, 32'h40);
		rd_check(OFS_RECEIVER_FLAGS, 32'h00);
		// transmit buffers
		axi_write(OFS_TX_IRQ_EN, 32'h7);
		axi_write(OFS_TX_FLAGS, 32'h5);
		repeat (2) @(posedge sys_clk);
		check_word({29'h0, tx_request}, 32'h5);
		check_bit(transmit_irq, 1'h1);
		tx_done <= 3'h1;
		@(posedge sys_clk);
		tx_done <= 3'h0;
		rd_check(OFS_TX_FLAGS, 32'h3);
		axi_write(OFS_TX_FLAGS, 32'h7);
		rd_check(OFS_TX_FLAGS, 32'h0);
		check_bit(transmit_irq, 1'h0);
		tx_done <= 3'h7;
		@(posedge sys_clk);
		tx_done <= 3'h0;
		rd_check(OFS_TX_FLAGS, 32'h7);
		// wake-up, filtered first, then unfiltered
		axi_write(OFS_CONTROL_ONE, 32'h84);
		for (int k = 0; k < 2; k++)
		begin
			axi_write(OFS_CONTROL_ZERO, 32'h06);
			wait_high(sleep_ack);
			glitch(8'h02);
			repeat (12) @(posedge sys_clk);
			check_bit(sleep_ack, k[0] ? 1'h0 : 1'h1);
			glitch(8'h0C);
			wait_high(module_active);
			rd_check(OFS_RECEIVER_FLAGS, 32'h80);
			check_bit(wakeup_irq, 1'h1);
			axi_write(OFS_RECEIVER_FLAGS, 32'h80);
			axi_write(OFS_CONTROL_ONE, 32'h80);
		end
		finish_test;
	end
endmodule // can_bit_timing_flags_test
